// ---- logic/table_unit_pkg.sv ----
`default_nettype none
package table_unit_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 8;
  localparam int OP_W = 2;
  localparam logic [OP_W-1:0] OP_FIND = 2'h0;
  localparam logic [OP_W-1:0] OP_GREATER = 2'h1;
  localparam logic [OP_W-1:0] OP_MOVE = 2'h2;
  localparam logic [WORD_W-1:0] ACC_MISS = 16'h0000;
  localparam logic [WORD_W-1:0] PTR_WRAP = 16'h0001;
  localparam logic [WORD_W-1:0] FIRST_DATA = 16'h0001;
  localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_OPND, S_SCAN, S_PTR, S_DATA, S_WDST, S_WPTR
  } state_e;
endpackage : table_unit_pkg
`default_nettype wire

// ---- logic/table_search_and_move_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Return offset of first equal word from start.
// - Bad offset or no match sets error.
// - Tables of zero to 255 words supported.
// - Search position starts at the offset held in accumulator.
// - Flags hold until rewritten, cleared at scan end.
// - Return offset of first strictly greater word.
// - No greater word: accumulator zero, error set.
// - Operand from memory word or instruction constant.
// - Move copies selected word, then pointer plus one.
// - First table word is pointer, data follows.
// - Move runs once per request, no limit.
// - Pointer equal to table length wraps to one; pointer past it skips the move.
// - Pointer zero or one selects first data word.
// - End flag set when stepped pointer equals length.
module table_search_and_move_unit
  import table_unit_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_START,
  input wire logic [table_unit_pkg::OP_W-1:0] I_OP,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_ACC,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_STACK1,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_STACK2,
  input wire logic I_OPERAND_IS_CONST,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_OPERAND_CONST,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_OPERAND_ADDR,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_DEST_ADDR,
  input wire logic I_END_OF_SCAN,
  input wire logic [table_unit_pkg::WORD_W-1:0] I_MEM_RDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic [table_unit_pkg::WORD_W-1:0] O_ACC,
  output logic O_ACC_WE,
  output logic O_TABLE_ERROR_FLAG,
  output logic O_TABLE_END_FLAG,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [table_unit_pkg::WORD_W-1:0] O_MEM_ADDR,
  output logic [table_unit_pkg::WORD_W-1:0] O_MEM_WDATA
);
  import table_unit_pkg::*;
  typedef struct packed {
    state_e state;
    logic [OP_W-1:0] op;
    logic [CNT_W-1:0] len, start, iss, o1, o2;
    logic [WORD_W-1:0] base, dest, opnd, ptr, word, acc, mem_addr, mem_wdata;
    logic issue_on, v1, v2, busy, done, acc_we, err, endf, mem_rd, mem_wr;
  } unit_s;
  unit_s st_q;
  unit_s st_d;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic hit;
    logic [WORD_W-1:0] len_w, new_ptr;
    hit = 1'b0;
    len_w = {CNT_ZERO, st_q.len};
    new_ptr = st_q.ptr + PTR_STEP;
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.acc_we = 1'b0;
    st_d.mem_rd = 1'b0;
    st_d.mem_wr = 1'b0;
    st_d.v1 = 1'b0;
    st_d.v2 = st_q.v1;
    st_d.o2 = st_q.o1;
    // Scan end clears both flags; a completion below overrides it.
    if (I_END_OF_SCAN)
    begin
      st_d.err = 1'b0;
      st_d.endf = 1'b0;
    end
    case (st_q.state)
      S_IDLE:
      begin
        // Requests are taken only here, so one finishes first.
        if (I_START)
        begin
          st_d.op = I_OP;
          st_d.busy = 1'b1;
          st_d.dest = I_DEST_ADDR;
          st_d.opnd = I_OPERAND_CONST;
          st_d.iss = CNT_ZERO;
          if (I_OP == OP_FIND)
          begin
            st_d.len = I_STACK2[CNT_W-1:0];
            st_d.base = I_STACK1;
            st_d.start = I_ACC[CNT_W-1:0];
            st_d.iss = I_ACC[CNT_W-1:0];
          end
          else
          begin
            st_d.len = I_STACK1[CNT_W-1:0];
            st_d.base = I_ACC;
            st_d.start = CNT_ZERO;
          end
          if (I_OP == OP_MOVE)
          begin
            st_d.mem_rd = 1'b1;
            st_d.mem_addr = I_ACC;
            st_d.v1 = 1'b1;
            st_d.state = S_PTR;
          end
          else if (!I_OPERAND_IS_CONST)
          begin
            st_d.mem_rd = 1'b1;
            st_d.mem_addr = I_OPERAND_ADDR;
            st_d.v1 = 1'b1;
            st_d.state = S_OPND;
          end
          else
            st_d.state = S_SCAN;
        end
      end
      S_OPND:
      begin
        if (st_q.v2)
        begin
          st_d.opnd = I_MEM_RDATA;
          st_d.state = S_SCAN;
        end
      end
      S_SCAN:
      begin
        // Issue one address per clock; data returns two edges later.
        if (st_q.issue_on)
        begin
          st_d.mem_rd = 1'b1;
          st_d.mem_addr = st_q.base + {CNT_ZERO, st_q.iss};
          st_d.v1 = 1'b1;
          st_d.o1 = st_q.iss;
          st_d.iss = st_q.iss + CNT_ONE;
          st_d.issue_on = (st_q.iss != st_q.len - CNT_ONE);
        end
        if (st_q.v2)
        begin
          if (st_q.op == OP_FIND)
            hit = (I_MEM_RDATA == st_q.opnd);
          else
            hit = (I_MEM_RDATA > st_q.opnd);
        end
        if (hit || (!st_q.issue_on && !st_q.v1))
        begin
          st_d.acc = hit ? {CNT_ZERO, st_q.o2} : ACC_MISS;
          st_d.err = !hit;
          st_d.issue_on = 1'b0;
          st_d.v1 = 1'b0;
          st_d.v2 = 1'b0;
          st_d.acc_we = 1'b1;
          st_d.done = 1'b1;
          st_d.busy = 1'b0;
          st_d.state = S_IDLE;
        end
      end
      S_PTR:
      begin
        if (st_q.v2)
        begin
          st_d.ptr = I_MEM_RDATA;
          if (I_MEM_RDATA > len_w || st_q.len == CNT_ZERO)
          begin
            st_d.endf = 1'b0;
            st_d.done = 1'b1;
            st_d.busy = 1'b0;
            st_d.state = S_IDLE;
          end
          else
          begin
            st_d.mem_rd = 1'b1;
            st_d.mem_addr = st_q.base + ((I_MEM_RDATA == ACC_MISS) ?
              FIRST_DATA : I_MEM_RDATA);
            st_d.v1 = 1'b1;
            st_d.state = S_DATA;
          end
        end
      end
      S_DATA:
      begin
        st_d.word = I_MEM_RDATA;
        if (st_q.v2)
          st_d.state = S_WDST;
      end
      S_WDST:
      begin
        st_d.mem_wr = 1'b1;
        st_d.mem_addr = st_q.dest;
        st_d.mem_wdata = st_q.word;
        st_d.state = S_WPTR;
      end
      S_WPTR:
      begin
        st_d.mem_wr = 1'b1;
        st_d.mem_addr = st_q.base;
        if (st_q.ptr >= len_w)
          st_d.mem_wdata = PTR_WRAP;
        else
          st_d.mem_wdata = new_ptr;
        st_d.endf = (st_q.ptr < len_w) && (new_ptr == len_w);
        st_d.done = 1'b1;
        st_d.busy = 1'b0;
        st_d.state = S_IDLE;
      end
      default:
      begin
        st_d.state = S_IDLE;
        st_d.busy = 1'b0;
      end
    endcase
    if (st_q.state == S_IDLE && I_START && I_OP != OP_MOVE)
      st_d.issue_on = (st_d.iss < st_d.len);
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign O_BUSY = st_q.busy;
  assign O_DONE = st_q.done;
  assign O_ACC = st_q.acc;
  assign O_ACC_WE = st_q.acc_we;
  assign O_TABLE_ERROR_FLAG = st_q.err;
  assign O_TABLE_END_FLAG = st_q.endf;
  assign O_MEM_RD = st_q.mem_rd;
  assign O_MEM_WR = st_q.mem_wr;
  assign O_MEM_ADDR = st_q.mem_addr;
  assign O_MEM_WDATA = st_q.mem_wdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  sequence s_move_req;
    st_q.state == S_IDLE && I_START && I_OP == OP_MOVE;
  endsequence
  sequence s_ptr_back;
    st_q.state == S_PTR && st_q.v2 && I_MEM_RDATA == ACC_MISS &&
      st_q.len != CNT_ZERO;
  endsequence
  a_miss_zero: assert property (O_DONE && O_ACC_WE &&
    O_TABLE_ERROR_FLAG |-> O_ACC == ACC_MISS) else $error("miss not zero");
  a_greater_miss: assert property (st_q.state == S_SCAN &&
    st_q.op == OP_GREATER && !st_q.issue_on && !st_q.v1 && !st_q.v2
    |=> O_DONE && O_TABLE_ERROR_FLAG)
    else $error("greater miss not flagged");
  a_find_offset: assert property (O_DONE && O_ACC_WE &&
    !O_TABLE_ERROR_FLAG && st_q.op == OP_FIND
    |-> O_ACC >= {CNT_ZERO, st_q.start} && O_ACC < {CNT_ZERO, st_q.len})
    else $error("find result out of range");
  a_greater_hit: assert property (st_q.state == S_SCAN &&
    st_q.v2 && st_q.op == OP_GREATER && I_MEM_RDATA > st_q.opnd
    |=> O_DONE && O_ACC == {CNT_ZERO, $past(st_q.o2)})
    else $error("greater hit offset wrong");
  a_scan_bound: assert property (st_q.state == S_SCAN &&
    st_q.v2 |-> st_q.o2 < st_q.len) else $error("read past table");
  a_scan_rate: assert property (st_q.state == S_SCAN &&
    st_q.issue_on |=> O_MEM_RD) else $error("scan skipped a clock");
  a_const_opnd: assert property (st_q.state == S_IDLE &&
    I_START && I_OPERAND_IS_CONST && I_OP != OP_MOVE
    |=> st_q.opnd == $past(I_OPERAND_CONST))
    else $error("constant operand lost");
  a_ptr_read: assert property (s_move_req
    |=> O_MEM_RD && O_MEM_ADDR == $past(I_ACC) ##1 st_q.state == S_PTR)
    else $error("pointer not read at table start");
  a_first_word: assert property (s_ptr_back
    |=> O_MEM_RD && O_MEM_ADDR == st_q.base + FIRST_DATA)
    else $error("zero pointer not on first word");
  a_wrap_one: assert property (st_q.state == S_WPTR &&
    st_q.ptr == {CNT_ZERO, st_q.len}
    |=> O_MEM_WR && O_MEM_WDATA == PTR_WRAP && !O_TABLE_END_FLAG)
    else $error("pointer did not wrap to one");
  a_step_one: assert property (st_q.state == S_WPTR &&
    st_q.ptr < {CNT_ZERO, st_q.len}
    |=> O_MEM_WDATA == $past(st_q.ptr) + PTR_STEP)
    else $error("pointer not stepped by one");
  a_flag_clear: assert property (I_END_OF_SCAN &&
    st_q.state == S_IDLE |=> !O_TABLE_ERROR_FLAG && !O_TABLE_END_FLAG)
    else $error("flags survived scan end");
endmodule : table_search_and_move_unit
`default_nettype wire

// ---- test/table_memory_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----
// Data word memory
// ----
module table_memory_model
  import table_unit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [table_unit_pkg::WORD_W-1:0] i_addr,
  input wire logic [table_unit_pkg::WORD_W-1:0] i_wdata,
  output logic [table_unit_pkg::WORD_W-1:0] o_rdata
);
  logic [WORD_W-1:0] words [0:511];
  // Read data stands one cycle; it then toggles so stale use shows.
  always @(posedge i_clock)
  begin
    if (i_rd)
      o_rdata <= words[i_addr[8:0]];
    else
      o_rdata <= ~o_rdata;
    if (i_wr)
      words[i_addr[8:0]] <= i_wdata;
  end
endmodule : table_memory_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import table_unit_pkg::*;
  logic clk, rst, start, is_const, eos, busy, done, acc_we, err, tend, rd, wr;
  logic [OP_W-1:0] op;
  logic [WORD_W-1:0] acc, stk1, stk2, opc, opa, dst, rdata, acc_out, addr;
  logic [WORD_W-1:0] wdata;
  int miscompares;
  int tests_run;

  table_search_and_move_unit uut (
    .I_CLOCK(clk), .I_RST(rst), .I_START(start), .I_OP(op), .I_ACC(acc),
    .I_STACK1(stk1), .I_STACK2(stk2), .I_OPERAND_IS_CONST(is_const),
    .I_OPERAND_CONST(opc), .I_OPERAND_ADDR(opa), .I_DEST_ADDR(dst),
    .I_END_OF_SCAN(eos), .I_MEM_RDATA(rdata), .O_BUSY(busy), .O_DONE(done),
    .O_ACC(acc_out), .O_ACC_WE(acc_we), .O_TABLE_ERROR_FLAG(err),
    .O_TABLE_END_FLAG(tend), .O_MEM_RD(rd), .O_MEM_WR(wr),
    .O_MEM_ADDR(addr), .O_MEM_WDATA(wdata)
  );
  table_memory_model mem (
    .i_clock(clk), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----
  // Shared tasks
  // ----
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [WORD_W:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic run(input logic [OP_W-1:0] o,
                     input logic [WORD_W-1:0] a, s1, s2, c);
    int n;
    @(negedge clk);
    op = o;
    acc = a;
    stk1 = s1;
    stk2 = s2;
    opc = c;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check("busy", 17'h00001, {16'h0000, busy});
    n = 0;
    while (done !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    check("done", 17'h00001, {16'h0000, done});
    check("idle at done", 17'h00000, {16'h0000, busy});
  endtask : run

  task automatic srch(input logic [OP_W-1:0] o,
                      input logic [WORD_W-1:0] a, s1, s2, c,
                      input logic [WORD_W:0] e);
    run(o, a, s1, s2, c);
    check("acc and error", e, {acc_out, err});
    check("acc write", 17'h00001, {16'h0000, acc_we});
  endtask : srch

  task automatic end_scan;
    @(negedge clk);
    eos = 1'b1;
    @(negedge clk);
    eos = 1'b0;
    check("flags after scan", 17'h00000, {15'h0000, err, tend});
  endtask : end_scan

  // ----
  // Scenarios
  // ----
  task automatic t_search;
    for (int i = 0; i < 6; i++)
      mem.words[32 + i] = 16'h0100 + 16'(i);
    mem.words[33] = 16'h00AA;
    mem.words[36] = 16'h00AA;
    srch(OP_FIND, 16'h2, 16'h20, 16'h6, 16'hAA, {16'h4, 1'b0});
    srch(OP_FIND, 16'h1, 16'h20, 16'h6, 16'hAA, {16'h1, 1'b0});
    srch(OP_FIND, 16'h6, 16'h20, 16'h6, 16'hAA, {ACC_MISS, 1'b1});
    srch(OP_FIND, 16'h0, 16'h20, 16'h6, 16'h5555, {ACC_MISS, 1'b1});
    end_scan();
    mem.words[496] = 16'h0103;
    is_const = 1'b0;
    opa = 16'h01F0;
    srch(OP_FIND, 16'h0, 16'h20, 16'h6, 16'h0, {16'h3, 1'b0});
    is_const = 1'b1;
    srch(OP_GREATER, 16'h20, 16'h6, 16'h0, 16'h102, {16'h3, 1'b0});
    srch(OP_GREATER, 16'h20, 16'h6, 16'h0, 16'h100, {16'h2, 1'b0});
    srch(OP_GREATER, 16'h20, 16'h6, 16'h0, 16'h105, {ACC_MISS, 1'b1});
    srch(OP_GREATER, 16'h20, 16'h0, 16'h0, 16'h0, {ACC_MISS, 1'b1});
    srch(2'h3, 16'h20, 16'h6, 16'h0, 16'h102, {16'h3, 1'b0});
    mem.words[318] = 16'h7777;
    srch(OP_FIND, 16'h0, 16'h40, 16'hFF, 16'h7777, {16'hFE, 1'b0});
    srch(OP_GREATER, 16'h40, 16'hFF, 16'h0, 16'h0, {16'hFE, 1'b0});
    srch(OP_FIND, 16'h0, 16'h40, 16'h0, 16'h0, {ACC_MISS, 1'b1});
  endtask : t_search

  task automatic t_move;
    int d [5] = '{1, 1, 2, 3, 1};
    int p [5] = '{1, 2, 3, 1, 2};
    for (int i = 1; i < 4; i++)
      mem.words[256 + i] = 16'h00C0 + 16'(i);
    dst = 16'h01F8;
    for (int i = 0; i < 5; i++)
    begin
      run(OP_MOVE, 16'h100, 16'h3, 16'h0, 16'h0);
      check("no acc write", 17'h00000, {16'h0000, acc_we});
      @(negedge clk);
      check("dest", {16'h00C0 + 16'(d[i]), 1'(p[i] == 3)},
            {mem.words[504], tend});
      check("ptr", {16'(p[i]), 1'b0}, {mem.words[256], 1'b0});
      if (i == 2)
        end_scan();
    end
    mem.words[256] = 16'h0005;
    run(OP_MOVE, 16'h100, 16'h3, 16'h0, 16'h0);
    @(negedge clk);
    check("skip", {16'h00C1, 1'b0}, {mem.words[504], tend});
  endtask : t_move

  initial
  begin
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    {start, eos, op, acc, stk1, stk2, opc, opa, dst} = '0;
    is_const = 1'b1;
    for (int i = 0; i < 512; i++)
      mem.words[i] = 16'h0000;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_search();
    t_move();
    print_verdict();
  end

  initial
  begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
